// ==== emp_pkg.sv ====
// Constants, types and field layouts of the external memory port.
// Assumes one APB clock domain; memory clock arrives as a sampled input.
package emp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_SPACE0 = 8'h00;
   localparam logic [7:0] OFS_SPACE3 = 8'h0c;
   localparam logic [7:0] OFS_ADDR   = 8'h10;
   localparam logic [7:0] OFS_CMD    = 8'h14;
   localparam logic [7:0] OFS_WDATA0 = 8'h18;
   localparam logic [7:0] OFS_WDATA3 = 8'h24;
   localparam logic [7:0] OFS_RDATA  = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2c;

   // Command register fields
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_SPACE_LSB = 1;
   localparam int CMD_BE_LSB    = 4;

   // Status register fields
   localparam int STAT_BUSY   = 0;
   localparam int STAT_RVALID = 1;
   localparam int STAT_READY  = 2;
   localparam int STAT_PEND   = 3;

   // Burst and latency figures, in output-clock cycles
   localparam logic [2:0] BURST_LEN     = 3'h4;
   localparam logic [3:0] SBSRAM_LAT    = 4'h2;
   localparam logic [3:0] SDRAM_CAS_LAT = 4'h3;

   typedef enum logic [1:0] {
      KIND_ASYNC = 2'b00,
      KIND_BURST = 2'b01,
      KIND_SDRAM = 2'b10
   } emp_kind_t;

   // Per-space control word; counts of 0 act as 1
   typedef struct packed {
      logic [1:0] kind;
      logic [3:0] wh;
      logic [3:0] write_strobe_cycles;
      logic [3:0] ws;
      logic [3:0] rh;
      logic [3:0] rst;
      logic [3:0] rs;
   } emp_space_cfg_t;

   localparam emp_space_cfg_t SPACE_RESET = 26'h0ffffff;

   // Memory-side pin bundle
   typedef struct packed {
      logic [3:0]  sel_n;
      logic [3:0]  be_n;
      logic [19:0] addr;
      logic        strb_rd_n;
      logic        strb_oe_n;
      logic        strb_wr_n;
      logic [31:0] dout;
      logic        dout_oe_n;
   } emp_pins_t;

   localparam emp_pins_t PINS_IDLE = {4'hf, 4'hf, 20'h00000, 3'h7,
                                      32'h00000000, 1'h1};

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD   = 3'b011,
      ST_ACT    = 3'b100,
      ST_WBURST = 3'b101,
      ST_RWAIT  = 3'b110,
      ST_PRE    = 3'b111
   } emp_state_t;

   // Counter load for a programmed cycle count
   function automatic logic [3:0] emp_load(input logic [3:0] n);
      emp_load = (n == 4'h0) ? 4'h0 : n - 4'h1;
   endfunction : emp_load

endpackage : emp_pkg

// ==== emp_top.sv ====
// External memory port: APB registers, async / burst SRAM / SDRAM cycles.
// Assumes mem_clock_in and async_wait_ready are sampled on pclk.
// Functional notes
// [R1] Async: shared strobes act as output enable, read strobe, write strobe.
// [R2] Async read: selects and output enable valid read-setup cycles first.
// [R3] Async read: selects held read-hold cycles after read strobe rises.
// [R4] Async write: selects valid write-setup cycles before write strobe.
// [R5] Async write: selects and data held write-hold cycles after strobe.
// [R6] Async write: data driven one cycle after selects.
// [R7] Every timing count programmable per space control register.
// [R8] Ready synchronised, sampled at clock rise; not-ready extends strobe.
// [R9] Far side holds each ready level about two output-clock periods.
// [R10] Burst SRAM: shared strobes act as address strobe, OE, write enable.
// [R11] Burst SRAM uses memory burst counter, four-word gapless bursts.
// [R12] SDRAM: shared strobes act as column strobe, write enable, row strobe.
// [R13] SDRAM uses memory burst counter, four-word gapless bursts.
// [R14] SDRAM read data captured three cycles after the read command.
// [R15] Output clock follows the memory clock input edges.
// [R16] Sync outputs launch and read data is captured at clock rise.
// [R17] Strobe lasts programmed count plus one per not-ready sample.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module emp_top (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Memory clock
   input  wire logic        mem_clock_in,
   output logic             mem_clock_out,
   // Memory pins
   input  wire logic        async_wait_ready,
   input  wire logic [31:0] ext_data_in,
   output logic      [31:0] ext_data_out,
   output logic             ext_data_oe_n,
   output logic      [3:0]  space_select_n,
   output logic      [3:0]  byte_lane_enable_n,
   output logic      [19:0] ext_word_addr,
   output logic             mstrobe_read_n,
   output logic             mstrobe_oe_n,
   output logic             mstrobe_write_n
);

   emp_pkg::emp_space_cfg_t space_cfg [4];
   emp_pkg::emp_state_t     state;
   emp_pkg::emp_state_t     next_state;
   emp_pkg::emp_pins_t      pins;
   emp_pkg::emp_pins_t      next_pins;
   logic [19:0] xfer_addr;
   logic        cmd_write;
   logic [1:0]  cmd_space;
   logic [3:0]  cmd_be;
   logic        go_pend;
   logic [31:0] wdata [4];
   logic [31:0] rbuf [4];
   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   logic [2:0]  beat;
   logic [2:0]  next_beat;
   logic        cap_en;
   logic        cap_last;
   logic        start;
   logic [2:0]  rd_left;
   logic [1:0]  drain_idx;
   logic        rdy_s1;
   logic        rdy_s2;
   logic [31:0] fifo_mem [2];
   logic        f_wptr;
   logic        f_rptr;
   logic [1:0]  f_count;
   logic [31:0] rd_word;

   // Clock follower and ready synchroniser
   wire tick = clk_en & mem_clock_in & ~mem_clock_out;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_clock_out <= 1'b0;
         rdy_s1        <= 1'b0;
         rdy_s2        <= 1'b0;
      end else if (clk_en) begin
         mem_clock_out <= mem_clock_in;                    // [R15]
         rdy_s1        <= async_wait_ready;                // [R8]
         rdy_s2        <= rdy_s1;
      end
   end

   // APB decode
   wire [7:0] reg_ofs   = paddr[7:0];
   wire       addr_hit  = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00)
                          && (reg_ofs <= emp_pkg::OFS_STATUS);
   wire       apb_done  = clk_en & psel & penable & pready;
   wire       wr_en     = apb_done & pwrite & addr_hit;
   wire       busy      = go_pend | (state != emp_pkg::ST_IDLE)
                          | (rd_left != 3'h0);
   wire [7:0] wd_rel    = reg_ofs - emp_pkg::OFS_WDATA0;
   wire       wr_space  = wr_en && (reg_ofs <= emp_pkg::OFS_SPACE3);
   wire       wr_addr   = wr_en && (reg_ofs == emp_pkg::OFS_ADDR);
   wire       wr_cmd    = wr_en && (reg_ofs == emp_pkg::OFS_CMD) && !busy;
   wire       wr_wdata  = wr_en && (reg_ofs >= emp_pkg::OFS_WDATA0)
                          && (reg_ofs <= emp_pkg::OFS_WDATA3);
   wire       f_valid   = (f_count != 2'h0);
   wire       f_in_rdy  = (f_count != 2'h2);
   wire       f_pop     = apb_done & ~pwrite & f_valid
                          & (reg_ofs == emp_pkg::OFS_RDATA);
   wire       f_push    = clk_en & (rd_left != 3'h0) & f_in_rdy;

   always_comb begin
      rd_word = 32'h00000000;
      if (reg_ofs <= emp_pkg::OFS_SPACE3)
         rd_word = {6'h00, space_cfg[reg_ofs[3:2]]};
      else if (reg_ofs == emp_pkg::OFS_ADDR)
         rd_word = {12'h000, xfer_addr};
      else if (reg_ofs == emp_pkg::OFS_CMD)
         rd_word = {24'h000000, cmd_be, 1'b0, cmd_space, cmd_write};
      else if (wd_rel <= 8'h0c)
         rd_word = wdata[wd_rel[3:2]];
      else if (reg_ofs == emp_pkg::OFS_RDATA)
         rd_word = f_valid ? fifo_mem[f_rptr] : 32'h00000000;
      else if (reg_ofs == emp_pkg::OFS_STATUS)
         rd_word = {28'h0000000, go_pend, rdy_s2, f_valid, busy};
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (clk_en) begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_hit;
         prdata  <= (psel & penable & ~pready & addr_hit & ~pwrite)
                    ? rd_word : 32'h00000000;
      end
   end

   // Register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            space_cfg[i] <= emp_pkg::SPACE_RESET;
            wdata[i]     <= 32'h00000000;
         end
         xfer_addr <= 20'h00000;
         cmd_write <= 1'b0;
         cmd_space <= 2'h0;
         cmd_be    <= 4'h0;
         go_pend   <= 1'b0;
      end else begin
         if (wr_space)
            space_cfg[reg_ofs[3:2]] <= pwdata[25:0];       // [R7]
         if (wr_addr)
            xfer_addr <= pwdata[19:0];
         if (wr_wdata)
            wdata[wd_rel[3:2]] <= pwdata;
         if (wr_cmd) begin
            cmd_write <= pwdata[emp_pkg::CMD_WRITE_BIT];
            cmd_space <= pwdata[emp_pkg::CMD_SPACE_LSB +: 2];
            cmd_be    <= pwdata[emp_pkg::CMD_BE_LSB +: 4];
            go_pend   <= 1'b1;
         end else if (start && tick) begin
            go_pend <= 1'b0;
         end
      end
   end

   // Sequencer decode
   emp_pkg::emp_space_cfg_t cfg;
   assign cfg = space_cfg[cmd_space];
   wire is_sdram = (cfg.kind == emp_pkg::KIND_SDRAM);
   wire is_burst = (cfg.kind == emp_pkg::KIND_BURST);
   wire is_async = !is_sdram && !is_burst;
   wire [3:0] setup_ld  = emp_pkg::emp_load(cmd_write ? cfg.ws : cfg.rs);
   wire [3:0] strobe_ld = emp_pkg::emp_load(cmd_write ? cfg.write_strobe_cycles : cfg.rst);
   wire [3:0] hold_ld   = emp_pkg::emp_load(cmd_write ? cfg.wh : cfg.rh);
   wire [3:0] sel_hot   = 4'h1 << cmd_space;

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_beat  = beat;
      next_pins  = pins;
      cap_en     = 1'b0;
      cap_last   = 1'b0;
      start      = 1'b0;
      unique case (state)
         emp_pkg::ST_IDLE: begin
            if (go_pend && rd_left == 3'h0) begin
               start           = 1'b1;
               next_pins.sel_n = ~sel_hot;
               next_pins.be_n  = ~cmd_be;
               next_pins.addr  = xfer_addr;
               next_beat       = 3'h0;
               if (is_sdram) begin
                  next_pins.addr      = {8'h00, xfer_addr[19:8]};
                  next_pins.strb_oe_n = 1'b0;                // [R12]
                  next_state          = emp_pkg::ST_ACT;
               end else if (is_burst) begin
                  next_pins.strb_rd_n = 1'b0;                // [R10]
                  if (cmd_write) begin
                     next_pins.strb_wr_n = 1'b0;             // [R10]
                     next_pins.dout      = wdata[0];
                     next_pins.dout_oe_n = 1'b0;
                     next_beat           = 3'h1;
                     next_state          = emp_pkg::ST_WBURST;
                  end else begin
                     next_pins.strb_oe_n = 1'b0;             // [R10]
                     next_cnt   = emp_pkg::SBSRAM_LAT - 4'h1;
                     next_state = emp_pkg::ST_RWAIT;
                  end
               end else begin
                  next_pins.strb_oe_n = cmd_write;           // [R1]
                  next_cnt   = setup_ld;                     // [R2] [R4]
                  next_state = emp_pkg::ST_SETUP;
               end
            end
         end
         emp_pkg::ST_SETUP: begin
            if (cmd_write) begin
               next_pins.dout      = wdata[0];               // [R6]
               next_pins.dout_oe_n = 1'b0;
            end
            if (cnt == 4'h0) begin
               next_pins.strb_wr_n = !cmd_write;             // [R1]
               next_pins.strb_rd_n = cmd_write;
               next_cnt   = strobe_ld;
               next_state = emp_pkg::ST_STROBE;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emp_pkg::ST_STROBE: begin
            if (rdy_s2) begin                                // [R8] [R17]
               if (cnt == 4'h0) begin
                  next_pins.strb_wr_n = 1'b1;
                  next_pins.strb_rd_n = 1'b1;
                  cap_en     = !cmd_write;
                  cap_last   = !cmd_write;
                  next_cnt   = hold_ld;                      // [R3] [R5]
                  next_state = emp_pkg::ST_HOLD;
               end else begin
                  next_cnt = cnt - 4'h1;
               end
            end
         end
         emp_pkg::ST_HOLD: begin
            if (cnt == 4'h0) begin
               next_pins  = emp_pkg::PINS_IDLE;              // [R3] [R5]
               next_state = emp_pkg::ST_IDLE;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emp_pkg::ST_ACT: begin
            next_pins.strb_oe_n = 1'b1;
            next_pins.strb_rd_n = 1'b0;                      // [R12]
            next_pins.addr      = {12'h000, xfer_addr[7:0]};
            if (cmd_write) begin
               next_pins.strb_wr_n = 1'b0;
               next_pins.dout      = wdata[0];
               next_pins.dout_oe_n = 1'b0;
               next_beat           = 3'h1;
               next_state          = emp_pkg::ST_WBURST;
            end else begin
               next_cnt   = emp_pkg::SDRAM_CAS_LAT - 4'h1;   // [R14]
               next_state = emp_pkg::ST_RWAIT;
            end
         end
         emp_pkg::ST_WBURST: begin
            next_pins.strb_rd_n = 1'b1;
            if (is_sdram)
               next_pins.strb_wr_n = 1'b1;
            if (beat == emp_pkg::BURST_LEN) begin
               next_pins  = emp_pkg::PINS_IDLE;
               next_state = emp_pkg::ST_IDLE;
               if (is_sdram) begin
                  next_pins.sel_n     = ~sel_hot;
                  next_pins.strb_oe_n = 1'b0;
                  next_pins.strb_wr_n = 1'b0;
                  next_state          = emp_pkg::ST_PRE;
               end
            end else begin
               next_pins.dout = wdata[beat[1:0]];            // [R11] [R13]
               next_beat      = beat + 3'h1;
            end
         end
         emp_pkg::ST_RWAIT: begin
            next_pins.strb_rd_n = 1'b1;
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else begin
               cap_en    = 1'b1;                             // [R16]
               next_beat = beat + 3'h1;
               if (beat == emp_pkg::BURST_LEN - 3'h1) begin  // [R11] [R13]
                  cap_last   = 1'b1;
                  next_pins  = emp_pkg::PINS_IDLE;
                  next_state = emp_pkg::ST_IDLE;
                  if (is_sdram) begin
                     next_pins.sel_n     = ~sel_hot;
                     next_pins.strb_oe_n = 1'b0;
                     next_pins.strb_wr_n = 1'b0;
                     next_state          = emp_pkg::ST_PRE;
                  end
               end
            end
         end
         emp_pkg::ST_PRE: begin
            next_pins  = emp_pkg::PINS_IDLE;
            next_state = emp_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer state advances only on output-clock rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= emp_pkg::ST_IDLE;
         cnt   <= 4'h0;
         beat  <= 3'h0;
         pins  <= emp_pkg::PINS_IDLE;
      end else if (tick) begin
         state <= next_state;
         cnt   <= next_cnt;
         beat  <= next_beat;
         pins  <= next_pins;                                 // [R16]
      end
   end

   // Read capture and drain into the two-entry buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++)
            rbuf[i] <= 32'h00000000;
         rd_left   <= 3'h0;
         drain_idx <= 2'h0;
      end else if (tick && cap_en) begin
         rbuf[beat[1:0]] <= ext_data_in;                     // [R16]
         if (cap_last) begin
            rd_left   <= is_async ? 3'h1 : emp_pkg::BURST_LEN;
            drain_idx <= 2'h0;
         end
      end else if (f_push) begin
         rd_left   <= rd_left - 3'h1;
         drain_idx <= drain_idx + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_mem[0] <= 32'h00000000;
         fifo_mem[1] <= 32'h00000000;
         f_wptr      <= 1'b0;
         f_rptr      <= 1'b0;
         f_count     <= 2'h0;
      end else begin
         if (f_push) begin
            fifo_mem[f_wptr] <= rbuf[drain_idx];
            f_wptr           <= ~f_wptr;
         end
         if (f_pop)
            f_rptr <= ~f_rptr;
         f_count <= f_count + {1'b0, f_push} - {1'b0, f_pop};
      end
   end

   // Pin outputs
   assign space_select_n     = pins.sel_n;
   assign byte_lane_enable_n = pins.be_n;
   assign ext_word_addr      = pins.addr;
   assign mstrobe_read_n     = pins.strb_rd_n;
   assign mstrobe_oe_n       = pins.strb_oe_n;
   assign mstrobe_write_n    = pins.strb_wr_n;
   assign ext_data_out       = pins.dout;
   assign ext_data_oe_n      = pins.dout_oe_n;

   // Checking helpers: ticks spent in a state, stalled strobe ticks
   logic [4:0] phase_ticks;
   logic [4:0] stall_ticks;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ticks <= 5'h00;
         stall_ticks <= 5'h00;
      end else if (tick) begin
         phase_ticks <= (next_state != state) ? 5'h00 : phase_ticks + 5'h01;
         stall_ticks <= (next_state != state) ? 5'h00
                      : stall_ticks + {4'h0, state == emp_pkg::ST_STROBE
                                             && !rdy_s2};
      end
   end
   wire leave = tick && (next_state != state);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ASYNC_OE: assert property (                           // [R1]
      (state == emp_pkg::ST_STROBE && is_async && !cmd_write)
      |-> (!mstrobe_oe_n && mstrobe_write_n))
      else $error("async read strobe without output enable");
   AST_SETUP_LEN: assert property (                          // [R2]
      (leave && state == emp_pkg::ST_SETUP)
      |-> (phase_ticks == {1'b0, setup_ld}))
      else $error("setup length differs from programmed count");
   AST_HOLD_LEN: assert property (                           // [R3]
      (leave && state == emp_pkg::ST_HOLD)
      |-> (phase_ticks == {1'b0, hold_ld}))
      else $error("hold length differs from programmed count");
   AST_WR_HOLD: assert property (                            // [R5]
      (state == emp_pkg::ST_HOLD && cmd_write)
      |-> (!ext_data_oe_n && space_select_n != 4'hf))
      else $error("write data or select dropped during hold");
   AST_DATA_LAG: assert property (                           // [R6]
      (tick && state == emp_pkg::ST_IDLE && start && is_async && cmd_write)
      |=> (ext_data_oe_n && state == emp_pkg::ST_SETUP))
      else $error("write data driven together with selects");
   AST_READY_EXT: assert property (                          // [R8]
      (tick && state == emp_pkg::ST_STROBE && !rdy_s2)
      |=> (state == emp_pkg::ST_STROBE && $stable(cnt)))
      else $error("not-ready sample did not extend strobe");
   AST_STROBE_LEN: assert property (                         // [R17]
      (leave && state == emp_pkg::ST_STROBE)
      |-> (phase_ticks == {1'b0, strobe_ld} + stall_ticks))
      else $error("strobe length differs from count plus stalls");
   AST_BURST_ADS: assert property (                          // [R10]
      (tick && is_burst) |=> (mstrobe_read_n == !$past(start)))
      else $error("burst address strobe not a single tick");
   AST_BURST_LEN: assert property (                          // [R13]
      (leave && state == emp_pkg::ST_RWAIT) |-> (beat == 3'h3))
      else $error("read burst not four words");
   AST_CAS_LAT: assert property (                            // [R14]
      (tick && cap_en && is_sdram && beat == 3'h0)
      |-> (phase_ticks == 5'h02))
      else $error("sdram read not captured at latency three");
   AST_CLK_FOLLOW: assert property (                         // [R15]
      clk_en |=> (mem_clock_out == $past(mem_clock_in)))
      else $error("output clock does not follow input");
   AST_SYNC_LAUNCH: assert property (                        // [R16]
      !tick |=> $stable(pins))
      else $error("memory pins changed away from clock rise");

endmodule : emp_top

// ==== emp_mem_model.sv ====
// Behavioural asynchronous memory on the far side of the memory port.
// Assumes pins change only at output-clock ticks of the port.
`timescale 1ns/1ns
module emp_mem_model (
   // Clock, reset, test control
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        stall,
   // Memory pins
   input  wire logic [3:0]  space_select_n,
   input  wire logic [19:0] ext_word_addr,
   input  wire logic        mstrobe_oe_n,
   input  wire logic        mstrobe_read_n,
   output logic      [31:0] ext_data_in,
   output logic             async_wait_ready
);
   logic [3:0]  rdy_lo;
   logic        used;
   logic [31:0] last;
   // Drive word only while selected with output enable low
   wire drive = (space_select_n != 4'hf) && !mstrobe_oe_n;
   assign ext_data_in      = last;
   assign async_wait_ready = (rdy_lo == 4'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_lo <= 4'h0;
         used   <= 1'b0;
         last   <= 32'h00000000;
      end else begin
         last <= drive ? ({12'h000, ext_word_addr} ^ 32'h5a5a0000) : ~last;
         if (mstrobe_read_n) begin
            used <= 1'b0;
         end else if (stall && !used) begin
            used   <= 1'b1;
            rdy_lo <= 4'h8; // Not-ready held two output periods
         end else if (rdy_lo != 4'h0) begin
            rdy_lo <= rdy_lo - 4'h1;
         end
      end
   end
endmodule : emp_mem_model

// ==== emp_top_tb_top.sv ====
// Self-checking bench: APB master, pin monitor, scoreboard queue.
// Assumes the asynchronous memory model and a pclk/4 memory clock.
`timescale 1ns/1ns
module emp_top_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, stall = 1'b0, cur_chk = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, ext_data_in;
   logic [31:0] ext_data_out, seed = 32'h4e8cbabe, exp_wdata = 32'h0;
   logic [1:0]  div = 2'h0;
   logic [3:0]  space_select_n, byte_lane_enable_n;
   logic [19:0] ext_word_addr;
   logic [32:0] expq[$], exp_sel = 33'h0, e;
   logic        pready, pslverr, mem_clock_out, async_wait_ready;
   logic        ext_data_oe_n, mstrobe_read_n, mstrobe_oe_n, mstrobe_write_n;
   logic        pm = 1'b0, pst = 1'b1, psl = 1'b1, st, sl;
   int          failures = 0, cmp_count = 0, cyc = 0, sc = 0, hc = 0;
   int          exp_setup = 1, exp_hold = 1, exp_strb = 2;
   initial forever #50 pclk = ~pclk;
   always @(posedge pclk) div <= div + 2'h1;
   emp_top emp_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_clock_in(div[1]), .mem_clock_out(mem_clock_out),
      .async_wait_ready(async_wait_ready), .ext_data_in(ext_data_in),
      .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
      .space_select_n(space_select_n),
      .byte_lane_enable_n(byte_lane_enable_n),
      .ext_word_addr(ext_word_addr), .mstrobe_read_n(mstrobe_read_n),
      .mstrobe_oe_n(mstrobe_oe_n), .mstrobe_write_n(mstrobe_write_n));
   emp_mem_model emp_mem_model_inst (.pclk(pclk), .presetn(presetn),
      .stall(stall), .space_select_n(space_select_n),
      .ext_word_addr(ext_word_addr), .mstrobe_oe_n(mstrobe_oe_n),
      .mstrobe_read_n(mstrobe_read_n), .ext_data_in(ext_data_in),
      .async_wait_ready(async_wait_ready));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string n, input logic [32:0] x,
                      input logic [32:0] s);
      cmp_count++;
      if (s !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic [32:0] x, output logic [31:0] r);
      @(posedge pclk);
      cur_chk = c;
      if (c) expq.push_back(x);
      psel <= 1'b1; pwrite <= wr; paddr <= {24'h0, a}; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic run_cmd(input logic [31:0] cmd);
      logic [31:0] r;
      apb(1'b1, emp_pkg::OFS_CMD, cmd, 1'b1, 33'h0, r);
      do
         apb(1'b0, emp_pkg::OFS_STATUS, 32'h0, 1'b0, 33'h0, r);
      while (r[emp_pkg::STAT_BUSY] | r[emp_pkg::STAT_PEND]);
   endtask : run_cmd
   always @(posedge pclk) begin
      if (pready === 1'b1 && cur_chk) begin
         e = expq.pop_front();
         chk("apb answer", e, {pslverr, prdata});
      end
      cyc++;
      if (cyc == 20000) begin
         failures++;
         complete_run;
      end
   end
   always @(negedge pclk) begin
      st = mstrobe_read_n & mstrobe_write_n;
      sl = &space_select_n;
      if (mem_clock_out && !pm) begin
         if (pst && !st) begin
            chk("setup", 33'(exp_setup), 33'(sc));
            chk("select", exp_sel, {24'h0, mstrobe_oe_n, byte_lane_enable_n,
                space_select_n});
            if (!mstrobe_write_n)
               chk("wdata", {1'b0, exp_wdata},
                   {ext_data_oe_n, ext_data_out});
         end
         if (!pst && st) begin
            chk("strobe", 33'(exp_strb), 33'(sc - exp_setup));
            hc = 0;
         end else begin
            hc++;
         end
         if (!psl && sl) chk("hold", 33'(exp_hold), 33'(hc));
         sc = sl ? 0 : sc + 1;
         pst = st;
         psl = sl;
      end
      pm = mem_clock_out;
   end
   initial begin : main
      logic [31:0] r, cfg;
      logic [19:0] a;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         apb(1'b0, 8'(4 * i), 32'h0, 1'b1, 33'h000ffffff, r);
      apb(1'b0, 8'h30, 32'h0, 1'b1, 33'h100000000, r);
      apb(1'b0, 8'h02, 32'h0, 1'b1, 33'h100000000, r);
      for (int k = 0; k < 2; k++) begin
         cfg = {8'h0, 4'(k + 1), 4'h2, 4'(2 * k + 1), 4'(2 - k), 4'h2,
                4'(3 * k)};
         apb(1'b1, 8'(4 * (k + 1)), cfg, 1'b1, 33'h0, r);
         apb(1'b0, 8'(4 * (k + 1)), 32'h0, 1'b1, {1'b0, cfg}, r);
         seed = lfsr(seed);
         a = seed[19:0];
         exp_wdata = lfsr(seed);
         apb(1'b1, emp_pkg::OFS_WDATA0, exp_wdata, 1'b1, 33'h0, r);
         apb(1'b1, emp_pkg::OFS_ADDR, {12'h0, a}, 1'b1, 33'h0, r);
         exp_setup = 2 * k + 1; exp_hold = k + 1;
         exp_sel = {24'h0, 1'b1, 4'h0, ~(4'h1 << (k + 1))};
         run_cmd(32'hf1 | 32'((k + 1) << 1));
         exp_setup = (k == 0) ? 1 : 3; exp_hold = 2 - k;
         exp_strb = 2 + 2 * k;
         exp_sel[8] = 1'b0;
         stall <= k[0];
         run_cmd(32'hf0 | 32'((k + 1) << 1));
         apb(1'b0, emp_pkg::OFS_RDATA, 32'h0, 1'b1,
             {1'b0, 12'h0, a} ^ 33'h05a5a0000, r);
         apb(1'b0, emp_pkg::OFS_RDATA, 32'h0, 1'b1, 33'h0, r);
      end
      // Burst SRAM read on space 0: four words, each the model's word for the one address
      apb(1'b1, emp_pkg::OFS_SPACE0, 32'h01000000, 1'b1, 33'h0, r);
      exp_setup = 0;
      exp_strb = 1;
      exp_hold = 4;
      exp_sel = {24'h0, 1'b0, 4'h0, 4'he};
      apb(1'b1, emp_pkg::OFS_CMD, 32'hf0, 1'b1, 33'h0, r);
      repeat (40) @(posedge pclk);
      for (int j = 0; j < 4; j++)
         apb(1'b0, emp_pkg::OFS_RDATA, 32'h0, 1'b1,
             {1'b0, 12'h0, a} ^ 33'h05a5a0000, r);
      repeat (4) @(posedge pclk);
      complete_run;
   end
endmodule : emp_top_tb_top
